// [logic/eim_meter.sv]
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
`include "eim_cfg.svh"

module eim_meter #(
    parameter int unsigned ADDR_W   = 12,
    parameter int unsigned SLOW_CYC = `EIM_TICK_SLOW_CYC,
    parameter int unsigned FAST_CYC = `EIM_TICK_FAST_CYC
) (
    input  wire logic              CLK,
    input  wire logic              RST_N,
    input  wire logic              CE,
    input  wire logic              EVENT_INPUT_A,
    input  wire logic              EVENT_INPUT_B,
    input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
    input  wire logic              S_AXI_AWVALID,
    output var  logic              S_AXI_AWREADY,
    input  wire logic [31:0]       S_AXI_WDATA,
    input  wire logic [3:0]        S_AXI_WSTRB,
    input  wire logic              S_AXI_WVALID,
    output var  logic              S_AXI_WREADY,
    output var  eim_pkg::eim_resp_t S_AXI_BRESP,
    output var  logic              S_AXI_BVALID,
    input  wire logic              S_AXI_BREADY,
    input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
    input  wire logic              S_AXI_ARVALID,
    output var  logic              S_AXI_ARREADY,
    output var  logic [31:0]       S_AXI_RDATA,
    output var  eim_pkg::eim_resp_t S_AXI_RRESP,
    output var  logic              S_AXI_RVALID,
    input  wire logic              S_AXI_RREADY
);
    import eim_pkg::*;

    eim_tick_if         tk ();
    eim_byte_t          ctl_ff;
    eim_byte_t          res_ff;
    eim_byte_t          cnt_ff;
    eim_state_t         st_ff;
    logic [1:0]         sync1_ff;
    logic [1:0]         sync2_ff;
    logic [1:0]         prev_ff;
    logic [1:0]         rise;
    logic [1:0]         fall;
    logic [1:0]         qual;
    logic               edge_ev;
    logic               tick;
    logic [ADDR_W-1:0]  awaddr_ff;
    logic [31:0]        wdata_ff;
    logic [3:0]         wstrb_ff;
    logic               wr_go;

    ////////////////////////////////////////////////////////////////////////////
    // Tick source

    assign tk.fast_sel = ctl_ff[`EIM_CTL_FAST_BIT];
    assign tick        = tk.tick;

    eim_tick_gen #(
        .SLOW_CYC (SLOW_CYC),
        .FAST_CYC (FAST_CYC)
    ) u_tick (
        .clk   (CLK),
        .rst_n (RST_N),
        .ce    (CE),
        .tk    (tk)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers and edge detect

    // Both inputs always tracked, so switching select gives no false edge
    for (genvar i = 0; i < 2; i++) begin : g_sync
        always_ff @(posedge CLK or negedge RST_N) begin
            if (!RST_N) begin
                sync1_ff[i] <= 1'b0;
                sync2_ff[i] <= 1'b0;
                prev_ff[i]  <= 1'b0;
            end else if (CE) begin
                sync1_ff[i] <= (i == 0) ? EVENT_INPUT_A : EVENT_INPUT_B;
                sync2_ff[i] <= sync1_ff[i];
                prev_ff[i]  <= sync2_ff[i];
            end
        end
        assign rise[i] = sync2_ff[i] & ~prev_ff[i];
        assign fall[i] = ~sync2_ff[i] & prev_ff[i];
        assign qual[i] = ctl_ff[`EIM_CTL_POL_A_BIT + i] ? fall[i] : rise[i];
    end

    assign edge_ev = ctl_ff[`EIM_CTL_SEL_BIT] ? qual[1] : qual[0];

    ////////////////////////////////////////////////////////////////////////////
    // Interval counter

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            st_ff <= EIM_IDLE;
        end else if (CE) begin
            case (st_ff)
                EIM_IDLE: begin
                    if (edge_ev) begin
                        st_ff <= EIM_RUN;
                    end
                end
                EIM_RUN:  st_ff <= EIM_RUN;
                default:  st_ff <= EIM_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            cnt_ff <= 8'h00;
        end else if (CE) begin
            if (edge_ev) begin
                cnt_ff <= 8'h00;
            end else if (st_ff == EIM_RUN && tick && cnt_ff < `EIM_CNT_STOP) begin
                cnt_ff <= cnt_ff + 8'h01;
            end
        end
    end

    // Edge wins over an overflow tick in the same cycle
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            res_ff <= `EIM_RESULT_RESET;
        end else if (CE) begin
            if (edge_ev && st_ff == EIM_RUN) begin
                res_ff <= cnt_ff;
            end else if (st_ff == EIM_RUN && tick && cnt_ff == `EIM_CNT_STOP) begin
                res_ff <= `EIM_CNT_OVER;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write

    assign wr_go = !S_AXI_AWREADY && !S_AXI_WREADY && !S_AXI_BVALID;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            S_AXI_AWREADY <= 1'b1;
            awaddr_ff     <= '0;
        end else if (CE) begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                S_AXI_AWREADY <= 1'b0;
                awaddr_ff     <= S_AXI_AWADDR;
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_AWREADY <= 1'b1;
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            S_AXI_WREADY <= 1'b1;
            wdata_ff     <= 32'h0000_0000;
            wstrb_ff     <= 4'h0;
        end else if (CE) begin
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                S_AXI_WREADY <= 1'b0;
                wdata_ff     <= S_AXI_WDATA;
                wstrb_ff     <= S_AXI_WSTRB;
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_WREADY <= 1'b1;
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP  <= EIM_OKAY;
        end else if (CE) begin
            if (wr_go) begin
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= (awaddr_ff == ADDR_W'({`EIM_CONTROL_IDX, 2'b00}) ||
                                 awaddr_ff == ADDR_W'({`EIM_RESULT_IDX, 2'b00}))
                                ? EIM_OKAY : EIM_SLVERR;
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    // Result is read-only; a write to it is accepted and dropped
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ctl_ff <= `EIM_CTL_RESET;
        end else if (CE) begin
            if (wr_go && wstrb_ff[0] && awaddr_ff == ADDR_W'({`EIM_CONTROL_IDX, 2'b00})) begin
                ctl_ff <= wdata_ff[7:0] & `EIM_CTL_WMASK;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            S_AXI_ARREADY <= 1'b1;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= 32'h0000_0000;
            S_AXI_RRESP   <= EIM_OKAY;
        end else if (CE) begin
            if (S_AXI_ARVALID && S_AXI_ARREADY) begin
                S_AXI_ARREADY <= 1'b0;
                S_AXI_RVALID  <= 1'b1;
                S_AXI_RRESP   <= EIM_OKAY;
                if (S_AXI_ARADDR == ADDR_W'({`EIM_RESULT_IDX, 2'b00})) begin
                    S_AXI_RDATA <= {24'h000000, res_ff};
                end else if (S_AXI_ARADDR == ADDR_W'({`EIM_CONTROL_IDX, 2'b00})) begin
                    S_AXI_RDATA <= {24'h000000, ctl_ff};
                end else begin
                    S_AXI_RDATA <= 32'h0000_0000;
                    S_AXI_RRESP <= EIM_SLVERR;
                end
            end else if (S_AXI_RVALID && S_AXI_RREADY) begin
                S_AXI_RVALID  <= 1'b0;
                S_AXI_ARREADY <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    a_sel_input_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (CE && st_ff == EIM_RUN && !ctl_ff[`EIM_CTL_SEL_BIT] && qual[0])
        |=> (res_ff == $past(cnt_ff) && cnt_ff == 8'h00))
        else $error("input A edge not captured");

    a_sel_input_b: assert property (@(posedge CLK) disable iff (!RST_N)
        (CE && st_ff == EIM_RUN && ctl_ff[`EIM_CTL_SEL_BIT] && !qual[1] && !tick)
        |=> $stable(res_ff))
        else $error("unselected input changed result");

    a_pol_ignore: assert property (@(posedge CLK) disable iff (!RST_N)
        (CE && !ctl_ff[`EIM_CTL_SEL_BIT] && ctl_ff[`EIM_CTL_POL_A_BIT] && rise[0])
        |-> !edge_ev)
        else $error("rising edge taken with falling polarity");

    a_count_step: assert property (@(posedge CLK) disable iff (!RST_N)
        (CE && st_ff == EIM_RUN && tick && !edge_ev && cnt_ff < `EIM_CNT_STOP)
        |=> cnt_ff == $past(cnt_ff) + 8'h01)
        else $error("counter did not step on tick");

    a_idle_hold: assert property (@(posedge CLK) disable iff (!RST_N)
        (st_ff == EIM_IDLE) |-> cnt_ff == 8'h00)
        else $error("counter moved before first edge");

    a_restart_zero: assert property (@(posedge CLK) disable iff (!RST_N)
        (CE && edge_ev) ##1 (CE && tick && !edge_ev) |=> cnt_ff == 8'h01)
        else $error("count did not restart from zero");

    a_sat_over: assert property (@(posedge CLK) disable iff (!RST_N)
        (CE && st_ff == EIM_RUN && tick && !edge_ev && cnt_ff == `EIM_CNT_STOP)
        |=> (cnt_ff == `EIM_CNT_STOP && res_ff == `EIM_CNT_OVER))
        else $error("saturation not flagged");

    a_single_edge: assert property (@(posedge CLK) disable iff (!RST_N)
        (CE && edge_ev) |=> !edge_ev)
        else $error("one edge gave two events");

    c_capture:  cover property (@(posedge CLK) disable iff (!RST_N)
        CE && st_ff == EIM_RUN && edge_ev && cnt_ff != 8'h00);
    c_overflow: cover property (@(posedge CLK) disable iff (!RST_N)
        res_ff == `EIM_CNT_OVER);
    c_input_b:  cover property (@(posedge CLK) disable iff (!RST_N)
        CE && ctl_ff[`EIM_CTL_SEL_BIT] && ctl_ff[`EIM_CTL_POL_B_BIT] && edge_ev);
endmodule

`default_nettype wire

// [logic/eim_cfg.svh]
`ifndef EIM_CFG_SVH
`define EIM_CFG_SVH

// Timing
`define EIM_CLK_PERIOD_NS  40
`define EIM_TICK_SLOW_NS   64000
`define EIM_TICK_FAST_NS   32000
`define EIM_TICK_SLOW_CYC  (`EIM_TICK_SLOW_NS / `EIM_CLK_PERIOD_NS)
`define EIM_TICK_FAST_CYC  (`EIM_TICK_FAST_NS / `EIM_CLK_PERIOD_NS)

// Register indices; byte address is four times the index
`define EIM_RESULT_IDX     8'hd7
`define EIM_CONTROL_IDX    8'hd8

// Control fields
`define EIM_CTL_FAST_BIT   1
`define EIM_CTL_SEL_BIT    2
`define EIM_CTL_POL_A_BIT  3
`define EIM_CTL_POL_B_BIT  4
`define EIM_CTL_WMASK      8'h1e
`define EIM_CTL_RESET      8'h00
`define EIM_RESULT_RESET   8'h00

// Counter limits
`define EIM_CNT_STOP       8'hfe
`define EIM_CNT_OVER       8'hff

`endif

// [logic/eim_pkg.sv]
package eim_pkg;

    typedef enum logic [1:0] {
        EIM_IDLE = 2'b01,
        EIM_RUN  = 2'b10
    } eim_state_t;

    typedef enum logic [1:0] {
        EIM_OKAY   = 2'b00,
        EIM_SLVERR = 2'b10
    } eim_resp_t;

    typedef logic [7:0] eim_byte_t;

endpackage

// [logic/eim_tick_if.sv]
`timescale 1ns/1ns
`default_nettype none

interface eim_tick_if;
    logic fast_sel;
    logic tick;

    modport gen  (input fast_sel, output tick);
    modport user (output fast_sel, input tick);
endinterface

`default_nettype wire

// [logic/eim_tick_gen.sv]
`timescale 1ns/1ns
`default_nettype none
`include "eim_cfg.svh"

module eim_tick_gen #(
    parameter int unsigned SLOW_CYC = `EIM_TICK_SLOW_CYC,
    parameter int unsigned FAST_CYC = `EIM_TICK_FAST_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    eim_tick_if.gen  tk
);
    localparam int unsigned DIV_W = $clog2(SLOW_CYC + 1);

    logic [DIV_W-1:0] div_ff;
    logic             tick_ff;
    logic [DIV_W-1:0] limit;

    // Free running: a capture never restarts the prescaler
    assign limit = tk.fast_sel ? DIV_W'(FAST_CYC - 1) : DIV_W'(SLOW_CYC - 1);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_ff  <= '0;
            tick_ff <= 1'b0;
        end else if (ce) begin
            if (div_ff >= limit) begin
                div_ff  <= '0;
                tick_ff <= 1'b1;
            end else begin
                div_ff  <= div_ff + 1'b1;
                tick_ff <= 1'b0;
            end
        end
    end

    assign tk.tick = tick_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    logic [15:0] gap_ff;
    logic        gap_ok_ff;
    logic        fast_q_ff;

    // Cycles since last tick; invalid after a tick rate change
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gap_ff    <= 16'h0000;
            gap_ok_ff <= 1'b0;
            fast_q_ff <= 1'b0;
        end else if (ce) begin
            fast_q_ff <= tk.fast_sel;
            if (tick_ff) begin
                gap_ff    <= 16'h0000;
                gap_ok_ff <= (fast_q_ff == tk.fast_sel);
            end else begin
                gap_ff <= gap_ff + 16'h0001;
                if (fast_q_ff != tk.fast_sel) begin
                    gap_ok_ff <= 1'b0;
                end
            end
        end
    end

    a_tick_period: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && tick_ff && gap_ok_ff && tk.fast_sel == fast_q_ff)
        |-> gap_ff == (tk.fast_sel ? 16'(FAST_CYC - 1) : 16'(SLOW_CYC - 1)))
        else $error("tick period wrong");
endmodule

`default_nettype wire

// [sim/eim_pulse_src.sv]
`timescale 1ns/1ns
`default_nettype none

module eim_pulse_src (
    input  wire logic clk,
    output var  logic line_a,
    output var  logic line_b
);
    int edges;

    initial begin
        line_a = 1'b0;
        line_b = 1'b0;
        edges = 0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Park the measured line at its idle level; may itself give one stray edge
    task automatic park(input logic sel, input logic pol);
        @(posedge clk);
        if (sel) begin
            line_b <= pol;
        end else begin
            line_a <= pol;
        end
        repeat (6) @(posedge clk);
    endtask

    // Qualifying edges every per cycles; widths alternate so the other edge is uneven.
    // The unselected line toggles every cycle, so a wrong select shows at once.
    task automatic emit(input logic sel, input logic pol, input int per, input int n,
                        input int wide);
        int w;
        for (int i = 0; i < n; i++) begin
            w = (i % 2) ? wide : 2;
            for (int c = 0; c < per; c++) begin
                @(posedge clk);
                if (sel) begin
                    line_b <= (c < w) ^ pol;
                    line_a <= ~line_a;
                end else begin
                    line_a <= (c < w) ^ pol;
                    line_b <= ~line_b;
                end
                if (c == 0) begin
                    edges++;
                end
            end
        end
    endtask
endmodule

`default_nettype wire

// [sim/edge_interval_meter_bench.sv]
`timescale 1ns/1ns
`default_nettype none
`include "eim_cfg.svh"

module edge_interval_meter_bench;
    import eim_pkg::*;

    localparam logic [11:0] A_RES = 12'(`EIM_RESULT_IDX) << 2;
    localparam logic [11:0] A_CTL = 12'(`EIM_CONTROL_IDX) << 2;
    localparam logic [11:0] A_BAD = 12'h364;

    logic        clk, rst_n, ce, ev_a, ev_b;
    logic [11:0] awaddr, araddr;
    logic        awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [31:0] wdata, rdata, r1, r2;
    logic [3:0]  wstrb;
    eim_resp_t   bresp, rresp;
    int          n_fail, total_checks;

    // Short ticks keep the saturation run near a thousand cycles
    eim_meter #(.ADDR_W(12), .SLOW_CYC(8), .FAST_CYC(4)) dut (
        .CLK(clk), .RST_N(rst_n), .CE(ce), .EVENT_INPUT_A(ev_a), .EVENT_INPUT_B(ev_b),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

    eim_pulse_src src (.clk(clk), .line_a(ev_a), .line_b(ev_b));

    always #20 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    // Entry waits an edge so no strobe is driven twice in one step
    task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                       input eim_resp_t er);
        logic done;
        @(posedge clk);
        done = 1'b0;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done) begin
            @(posedge clk);
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                done = 1'b1;
                bready <= 1'b0;
                chk("bresp", 32'(er), 32'(bresp));
            end
        end
    endtask

    task automatic axr(input logic [11:0] a, output logic [31:0] d, input eim_resp_t er);
        logic done;
        @(posedge clk);
        done = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done) begin
            @(posedge clk);
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                done = 1'b1;
                rready <= 1'b0;
                d = rdata;
                chk("rresp", 32'(er), 32'(rresp));
            end
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Unselected polarity bit is set opposite, so only the selected one may count
    task automatic meas(input logic [2:0] cfg);
        logic        s, p, f;
        int          per, k;
        logic [31:0] ctl;
        f = cfg[0];
        s = cfg[1];
        p = cfg[2];
        per = f ? 4 : 8;
        k = 40 / per;
        ctl = {27'd0, (s ? p : ~p), (s ? ~p : p), s, f, 1'b0};
        axw(A_CTL, ctl, 4'h1, EIM_OKAY);
        axr(A_CTL, r1, EIM_OKAY);
        chk("control", ctl, r1);
        src.park(s, p);
        src.edges = 0;
        fork
            src.emit(s, p, 40, 4, 2 + 2 * per);
            begin
                wait (src.edges == 2);
                repeat (8) @(posedge clk);
                axr(A_RES, r1, EIM_OKAY);
                wait (src.edges == 3);
                repeat (8) @(posedge clk);
                axr(A_RES, r2, EIM_OKAY);
            end
        join
        // Free-running prescaler: a tick on the edge cycle is lost, so k or k-1
        chk("interval", 32'(k), (r1 === 32'(k - 1)) ? 32'(k) : r1);
        chk("next interval", r1, r2);
        $display("test config %0d done", cfg);
    endtask

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        ce = 1'b1;
        awaddr = '0;
        araddr = '0;
        awvalid = 1'b0;
        wvalid = 1'b0;
        bready = 1'b0;
        arvalid = 1'b0;
        rready = 1'b0;
        wdata = '0;
        wstrb = '0;
        n_fail = 0;
        total_checks = 0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        axr(A_CTL, r1, EIM_OKAY);
        chk("control reset", 32'h0, r1);
        axr(A_RES, r1, EIM_OKAY);
        chk("result reset", 32'h0, r1);
        axr(A_BAD, r1, EIM_SLVERR);
        chk("unmapped read", 32'h0, r1);
        axw(A_BAD, 32'h0000_001e, 4'hf, EIM_SLVERR);
        axw(A_CTL, 32'hffff_ffff, 4'hf, EIM_OKAY);
        axw(A_CTL, 32'h0, 4'h0, EIM_OKAY);
        axr(A_CTL, r1, EIM_OKAY);
        chk("control mask", 32'h0000_001e, r1);
        axw(A_RES, 32'h0000_0055, 4'hf, EIM_OKAY);
        axr(A_RES, r1, EIM_OKAY);
        chk("result read only", 32'h0, r1);
        $display("test registers done");
        for (int i = 0; i < 8; i++) begin
            meas(3'(i));
        end
        axw(A_CTL, 32'h0000_0002, 4'h1, EIM_OKAY);
        src.park(1'b0, 1'b0);
        src.edges = 0;
        fork
            src.emit(1'b0, 1'b0, 1100, 2, 2);
            begin
                wait (src.edges == 1);
                repeat (1080) @(posedge clk);
                axr(A_RES, r1, EIM_OKAY);
                wait (src.edges == 2);
                repeat (8) @(posedge clk);
                axr(A_RES, r2, EIM_OKAY);
            end
        join
        chk("over range", 32'h0000_00ff, r1);
        chk("stopped count", 32'h0000_00fe, r2);
        $display("test saturation done");
        // Pulse while frozen must be missed; counter sits at FE, result at FF
        ce <= 1'b0;
        src.emit(1'b0, 1'b0, 4, 1, 2);
        repeat (4) @(posedge clk);
        ce <= 1'b1;
        axr(A_RES, r1, EIM_OKAY);
        chk("frozen result", 32'h0000_00ff, r1);
        $display("test clock enable done");
        end_sim();
    end

    // Tests need about 3700 cycles
    initial begin
        #(20000 * 40);
        n_fail++;
        end_sim();
    end
endmodule

`default_nettype wire
